// *** verilog/spdte_pkg.sv ***
package spdte_pkg;

  localparam int NPIN = 2;
  localparam int MEM_WORDS = 24;
  localparam int REGS_PER_SET = 6;

  // byte addresses on the register bus
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DIV_OFS = 8'h04;
  localparam logic [7:0] ROLE_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0C;
  localparam logic [7:0] DATA0_OFS = 8'h10;
  localparam logic [7:0] DATA1_OFS = 8'h14;
  localparam logic [7:0] MEM_BASE = 8'h40;
  localparam logic [7:0] MEM_END = 8'hA0;

  // control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_LOOP_BIT = 1;
  localparam int CTRL_VEVEN_BIT = 2;
  localparam int CTRL_VODD_BIT = 3;
  localparam int CTRL_EXTREF_BIT = 4;

  // status register fields
  localparam int STAT_LAST_BIT = 16;
  localparam int STAT_CHK_BIT = 17;

  // reset values
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [1:0] ROLE_RESET = 2'h0;

  // word groups inside the bit store
  localparam logic [4:0] LSTAT_IDX = 5'h00;
  localparam logic [4:0] RSTAT_IDX = 5'h06;
  localparam logic [4:0] LUSER_IDX = 5'h0C;
  localparam logic [4:0] RUSER_IDX = 5'h12;

  // sequence counts
  localparam logic [8:0] LAST_SUB = 9'h17F;
  localparam logic [5:0] LAST_HALF = 6'h3F;
  localparam logic [4:0] FIRST_AUDIO_SLOT = 5'h04;
  localparam logic [4:0] VALID_SLOT = 5'h1C;
  localparam logic [4:0] USER_SLOT = 5'h1D;
  localparam logic [4:0] STATUS_SLOT = 5'h1E;
  localparam logic [4:0] PARITY_SLOT = 5'h1F;
  localparam logic [5:0] PRE_END_HALF = 6'h07;

  // preamble half-cell patterns, first half-cell in the msb, after a low line
  localparam logic [7:0] PRE_B = 8'hE8;
  localparam logic [7:0] PRE_M = 8'hE2;
  localparam logic [7:0] PRE_W = 8'hE4;

  // clk cycles without a reference clock edge before it is called unstable
  localparam logic [7:0] CHK_LIMIT = 8'hFF;

endpackage

// *** verilog/spdte_bmc.sv ***
`timescale 1ns/10ps
module spdte_bmc
(
  input wire logic clk,        // system clock
  input wire logic rst_b,      // independent_clocking reset, active low
  input wire logic run,        // mode active
  input wire logic half_tick,  // one half-cell boundary
  input wire logic pre_active, // half-cell belongs to the preamble
  input wire logic pre_first,  // first half-cell of the preamble
  input wire logic pre_bit,    // preamble pattern for this half-cell
  input wire logic second_half, // second half of a data cell
  input wire logic data_bit,   // data cell value
  output logic line            // encoded line level
);

  logic ref_level;
  logic next_line;

  // preamble patterns are relative to the level that ended the last subframe
  assign next_line = pre_active ? (pre_bit ^ (pre_first ? line : ref_level)) :
                     (second_half ? (line ^ data_bit) : ~line);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      line <= 1'b0;
      ref_level <= 1'b0;
    end
    else if (!run)
    begin
      line <= 1'b0;
      ref_level <= 1'b0;
    end
    else if (half_tick)
    begin
      line <= next_line;
      if (pre_first)
      begin
        ref_level <= line;
      end
    end
  end

  property cell_edge_p;
    @(posedge clk) disable iff (!rst_b)
    run && half_tick && !pre_active && !second_half |=> line != $past(line);
  endproperty
  cell_edge_a: assert property (cell_edge_p)
    else $error("no transition at bit-cell boundary");

  property mid_cell_p;
    @(posedge clk) disable iff (!rst_b)
    run && half_tick && !pre_active && second_half |=> (line != $past(line)) == $past(data_bit);
  endproperty
  mid_cell_a: assert property (mid_cell_p)
    else $error("mid-cell transition does not match data bit");

endmodule

// *** verilog/spdte_top.sv ***
// Design decisions made here: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
module spdte_top
(
  input wire logic clk,                  // system clock, 20 MHz
  input wire logic rst_b,                // independent_clocking reset, active low
  input wire logic wb_cyc_i,             // wishbone cycle
  input wire logic wb_stb_i,             // wishbone strobe
  input wire logic wb_we_i,              // wishbone write enable
  input wire logic [7:0] wb_adr_i,       // wishbone byte address
  input wire logic [3:0] wb_sel_i,       // wishbone byte lanes
  input wire logic [31:0] wb_dat_i,      // wishbone write data
  output logic [31:0] wb_dat_o,          // wishbone read data
  output logic wb_ack_o,                 // wishbone acknowledge
  input wire logic tx_high_freq_clock_pin, // external reference clock level
  output logic [1:0] serial_data_pin_o,  // encoded stream per data pin
  output logic [1:0] serial_data_pin_oe  // pin drive enable, high drives
);

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic [31:0] spdte_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  localparam int MEM_WORDS_M1 = spdte_pkg::MEM_WORDS - 1;
  logic consumer_audio_enable;
  logic loopback;
  logic valid_even;
  logic valid_odd;
  logic ext_ref;
  logic [7:0] tx_bit_clock_divider;
  logic [1:0] serializer_role;
  logic [23:0] data_hold [0:1];
  logic [23:0] sample [0:1];
  logic [31:0] bit_store [0:MEM_WORDS_M1];
  logic last_flag;
  logic chk_fail;
  logic [8:0] sub;
  logic [5:0] hc;
  logic [7:0] dcnt;
  logic hf_prev;
  logic [7:0] gap;
  logic [1:0] par;

  ////////////////////////////////////////////////////////////////////////////
  // register bus decode

  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i;
  wire ctrl_hit = wb_adr_i == spdte_pkg::CTRL_OFS;
  wire div_hit = wb_adr_i == spdte_pkg::DIV_OFS;
  wire role_hit = wb_adr_i == spdte_pkg::ROLE_OFS;
  wire stat_hit = wb_adr_i == spdte_pkg::STAT_OFS;
  wire d0_hit = wb_adr_i == spdte_pkg::DATA0_OFS;
  wire d1_hit = wb_adr_i == spdte_pkg::DATA1_OFS;
  wire mem_hit = (wb_adr_i >= spdte_pkg::MEM_BASE) && (wb_adr_i < spdte_pkg::MEM_END);
  wire [7:0] mem_ofs = wb_adr_i - spdte_pkg::MEM_BASE;
  wire [4:0] mem_idx = mem_ofs[6:2];

  wire [31:0] ctrl_word = {27'h0000000, ext_ref, valid_odd, valid_even, loopback,
                           consumer_audio_enable};
  wire [31:0] stat_word = {14'h0000, chk_fail, last_flag, 7'h00, sub};
  wire [31:0] next_ctrl = spdte_merge(ctrl_word, wb_dat_i, wb_sel_i);
  wire [31:0] next_div = spdte_merge({24'h000000, tx_bit_clock_divider}, wb_dat_i, wb_sel_i);
  wire [31:0] next_role = spdte_merge({30'h00000000, serializer_role}, wb_dat_i, wb_sel_i);
  wire [31:0] next_d0 = spdte_merge({8'h00, data_hold[0]}, wb_dat_i, wb_sel_i);
  wire [31:0] next_d1 = spdte_merge({8'h00, data_hold[1]}, wb_dat_i, wb_sel_i);
  wire [31:0] next_mem = spdte_merge(bit_store[mem_idx], wb_dat_i, wb_sel_i);
  wire last_clr = wr & stat_hit & wb_sel_i[2] & wb_dat_i[spdte_pkg::STAT_LAST_BIT];
  wire chk_clr = wr & stat_hit & wb_sel_i[2] & wb_dat_i[spdte_pkg::STAT_CHK_BIT];

  // unmapped addresses read as zero and ignore writes
  wire [31:0] next_dat = ctrl_hit ? ctrl_word :
                         div_hit ? {24'h000000, tx_bit_clock_divider} :
                         role_hit ? {30'h00000000, serializer_role} :
                         stat_hit ? stat_word :
                         d0_hit ? {8'h00, data_hold[0]} :
                         d1_hit ? {8'h00, data_hold[1]} :
                         mem_hit ? bit_store[mem_idx] : 32'h00000000;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= req;
      wb_dat_o <= req ? next_dat : wb_dat_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      consumer_audio_enable <= 1'b0;
      loopback <= 1'b0;
      valid_even <= 1'b0;
      valid_odd <= 1'b0;
      ext_ref <= 1'b0;
    end
    else if (wr && ctrl_hit)
    begin
      consumer_audio_enable <= next_ctrl[spdte_pkg::CTRL_EN_BIT];
      // loopback would feed the encoded stream back; it is dropped on entry
      loopback <= next_ctrl[spdte_pkg::CTRL_LOOP_BIT] & ~next_ctrl[spdte_pkg::CTRL_EN_BIT];
      valid_even <= next_ctrl[spdte_pkg::CTRL_VEVEN_BIT];
      valid_odd <= next_ctrl[spdte_pkg::CTRL_VODD_BIT];
      ext_ref <= next_ctrl[spdte_pkg::CTRL_EXTREF_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tx_bit_clock_divider <= spdte_pkg::DIV_RESET;
      serializer_role <= spdte_pkg::ROLE_RESET;
      data_hold[0] <= 24'h000000;
      data_hold[1] <= 24'h000000;
    end
    else if (wr)
    begin
      tx_bit_clock_divider <= div_hit ? next_div[7:0] : tx_bit_clock_divider;
      serializer_role <= role_hit ? next_role[1:0] : serializer_role;
      data_hold[0] <= d0_hit ? next_d0[23:0] : data_hold[0];
      data_hold[1] <= d1_hit ? next_d1[23:0] : data_hold[1];
    end
  end

  // store is not double buffered; a write to the word in use races the encoder
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int w = 0; w < spdte_pkg::MEM_WORDS; w++)
      begin
        bit_store[w] <= 32'h00000000;
      end
    end
    else if (wr && mem_hit)
    begin
      bit_store[mem_idx] <= next_mem;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference clock, divider and clock check

  wire hf_rise = tx_high_freq_clock_pin & ~hf_prev;
  wire ref_tick = ext_ref ? hf_rise : 1'b1;
  wire half_tick = consumer_audio_enable & ref_tick & (dcnt == tx_bit_clock_divider);
  wire chk_on = consumer_audio_enable & ext_ref;
  wire chk_evt = chk_on & (gap == spdte_pkg::CHK_LIMIT);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hf_prev <= 1'b0;
      dcnt <= 8'h00;
      gap <= 8'h00;
      chk_fail <= 1'b0;
    end
    else
    begin
      hf_prev <= tx_high_freq_clock_pin;
      if (!consumer_audio_enable || half_tick)
        dcnt <= 8'h00;
      else if (ref_tick)
        dcnt <= dcnt + 8'h01;
      if (!chk_on || hf_rise)
        gap <= 8'h00;
      else if (gap != spdte_pkg::CHK_LIMIT)
        gap <= gap + 8'h01;
      chk_fail <= chk_evt | (chk_fail & ~chk_clr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // subframe sequencer

  wire sub_end = half_tick & (hc == spdte_pkg::LAST_HALF);
  wire last_evt = sub_end & (sub == spdte_pkg::LAST_SUB);
  wire [4:0] slot = hc[5:1];
  wire second_half = hc[0];
  wire pre_active = slot < spdte_pkg::FIRST_AUDIO_SLOT;
  wire pre_first = hc == 6'h00;
  wire [7:0] pre_pat = (sub == 9'h000) ? spdte_pkg::PRE_B :
                       sub[0] ? spdte_pkg::PRE_W : spdte_pkg::PRE_M;
  wire [2:0] pre_pos = 3'h7 - hc[2:0];
  wire pre_bit = pre_pat[pre_pos];

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hc <= 6'h00;
      sub <= 9'h000;
      last_flag <= 1'b0;
    end
    else
    begin
      if (!consumer_audio_enable)
      begin
        hc <= 6'h00;
        sub <= 9'h000;
      end
      else if (half_tick)
      begin
        hc <= hc + 6'h01;
        if (sub_end)
          sub <= (sub == spdte_pkg::LAST_SUB) ? 9'h000 : sub + 9'h001;
      end
      last_flag <= last_evt | (last_flag & ~last_clr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel status, user and validity bits shared by every pin

  wire [2:0] blk_word = sub[8:6];
  wire [4:0] blk_bit = sub[5:1];
  wire [4:0] cs_idx = (sub[0] ? spdte_pkg::RSTAT_IDX : spdte_pkg::LSTAT_IDX) + {2'h0, blk_word};
  wire [4:0] ud_idx = (sub[0] ? spdte_pkg::RUSER_IDX : spdte_pkg::LUSER_IDX) + {2'h0, blk_word};
  wire [31:0] cs_word = bit_store[cs_idx];
  wire [31:0] ud_word = bit_store[ud_idx];
  wire c_bit = cs_word[blk_bit];
  wire u_bit = ud_word[blk_bit];
  wire v_bit = sub[0] ? valid_odd : valid_even;
  wire [4:0] audio_idx = slot - spdte_pkg::FIRST_AUDIO_SLOT;
  wire load_sample = half_tick & (hc == spdte_pkg::PRE_END_HALF);
  wire par_step = half_tick & second_half & ~pre_active & (slot != spdte_pkg::PARITY_SLOT);

  ////////////////////////////////////////////////////////////////////////////
  // per pin slot bits, parity and encoder, all driven from one sequencer

  logic [1:0] pin_bit;

  for (genvar i = 0; i < spdte_pkg::NPIN; i++)
  begin : g_pin
    logic [23:0] smp;
    logic line;
    assign smp = sample[i];
    assign pin_bit[i] = (slot == spdte_pkg::PARITY_SLOT) ? par[i] :
                        (slot == spdte_pkg::STATUS_SLOT) ? c_bit :
                        (slot == spdte_pkg::USER_SLOT) ? u_bit :
                        (slot == spdte_pkg::VALID_SLOT) ? v_bit : smp[audio_idx];

    always_ff @(posedge clk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        sample[i] <= 24'h000000;
        par[i] <= 1'b0;
        serial_data_pin_oe[i] <= 1'b0;
        serial_data_pin_o[i] <= 1'b0;
      end
      else
      begin
        if (load_sample)
          sample[i] <= data_hold[i];
        if (!consumer_audio_enable || sub_end)
          par[i] <= 1'b0;
        else if (par_step)
          par[i] <= par[i] ^ pin_bit[i];
        serial_data_pin_oe[i] <= consumer_audio_enable & serializer_role[i];
        serial_data_pin_o[i] <= line & serializer_role[i];
      end
    end

    spdte_bmc u_bmc
    (
      .clk(clk),
      .rst_b(rst_b),
      .run(consumer_audio_enable),
      .half_tick(half_tick),
      .pre_active(pre_active),
      .pre_first(pre_first),
      .pre_bit(pre_bit),
      .second_half(second_half),
      .data_bit(pin_bit[i]),
      .line(line)
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  mode_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
    !consumer_audio_enable |=> (sub == 9'h000) && (hc == 6'h00))
    else $error("sequencer moves while the mode is off");

  pin_role_a: assert property (@(posedge clk) disable iff (!rst_b)
    serial_data_pin_oe[0] |-> $past(serializer_role[0] && consumer_audio_enable))
    else $error("pin driven without transmitter role");

  block_wrap_a: assert property (@(posedge clk) disable iff (!rst_b)
    last_evt && consumer_audio_enable |=> (sub == 9'h000) && last_flag)
    else $error("block did not wrap after subframe 383");

  slot_step_a: assert property (@(posedge clk) disable iff (!rst_b)
    sub_end && !last_evt |=> sub == $past(sub) + 9'h001)
    else $error("slot counter skipped a subframe");

  no_loop_a: assert property (@(posedge clk) disable iff (!rst_b)
    consumer_audio_enable |-> !loopback)
    else $error("loopback set while mode active");

  clk_check_a: assert property (@(posedge clk) disable iff (!rst_b)
    chk_on && !hf_rise && (gap == 8'hFE) ##1 chk_on && !hf_rise |=> chk_fail)
    else $error("stalled reference not flagged");

  preamble_kind_a: assert property (@(posedge clk) disable iff (!rst_b)
    pre_first |-> ((pre_pat == spdte_pkg::PRE_B) == (sub == 9'h000)))
    else $error("preamble B outside frame 0 left subframe");

  right_pre_a: assert property (@(posedge clk) disable iff (!rst_b)
    pre_first && sub[0] |-> pre_pat == spdte_pkg::PRE_W)
    else $error("right subframe without preamble W");

  bus_ack_a: assert property (@(posedge clk) disable iff (!rst_b)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single cycle");

endmodule

// *** sim/spdte_rx_model.sv ***
`timescale 1ns/10ps
module spdte_rx_model
(
  input wire logic clk, // system clock
  input wire logic rst_b, // independent_clocking reset, active low
  input wire logic line, // encoded line at the cable
  input wire logic oe, // line driven by the sender
  output logic sub_stb, // one subframe captured
  output logic [63:0] sub_word // its 64 half-cells, first in the msb
);
  // one sample per clk, so only usable while a half-cell lasts one clk
  logic [63:0] sr;
  logic [5:0] cnt;
  logic locked;
  wire logic [63:0] next_sr = {sr[62:0], line};
  // three equal half-cells after a change occur only inside a preamble
  wire logic pre_seen = (next_sr[3:0] == 4'h7) || (next_sr[3:0] == 4'h8);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sr <= 64'h0;
      cnt <= 6'h0;
      locked <= 1'b0;
      sub_stb <= 1'b0;
      sub_word <= 64'h0;
    end
    else
    begin
      sr <= next_sr;
      sub_stb <= 1'b0;
      if (!oe)
      begin
        locked <= 1'b0;
        cnt <= 6'h0;
      end
      else if (!locked)
      begin
        locked <= pre_seen;
        cnt <= 6'h3;
      end
      else
      begin
        cnt <= cnt + 6'h1;
        sub_stb <= (cnt == 6'h3F);
        if (cnt == 6'h3F)
          sub_word <= next_sr;
      end
    end
  end
endmodule

// *** sim/spdif_transmit_encoder_test.sv ***
`timescale 1ns/10ps
module spdif_transmit_encoder_test;
  logic clk, rst_b, cyc, stb, we, ack, ref_pin, ref_run, s0, s1;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [1:0] pin_o, pin_oe;
  logic [2:0] ref_cnt;
  logic [63:0] w0, w1;
  logic [31:0] mem [24];
  logic [23:0] aud [2];
  int fail_count, num_checks;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  spdte_top uut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .tx_high_freq_clock_pin(ref_pin), .serial_data_pin_o(pin_o), .serial_data_pin_oe(pin_oe));
  spdte_rx_model rx0 (.clk(clk), .rst_b(rst_b), .line(pin_o[0]), .oe(pin_oe[0]),
    .sub_stb(s0), .sub_word(w0));
  spdte_rx_model rx1 (.clk(clk), .rst_b(rst_b), .line(pin_o[1]), .oe(pin_oe[1]),
    .sub_stb(s1), .sub_word(w1));

  // reference clock with a rising edge every 6 clk cycles
  always @(posedge clk)
    if (ref_run)
    begin
      ref_cnt <= (ref_cnt == 3'h5) ? 3'h0 : ref_cnt + 3'h1;
      ref_pin <= (ref_cnt < 3'h3);
    end

  task check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    q = rdat;
    check(ack, 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    check(q & mask, exp);
  endtask

  task decode(input logic [63:0] w, output logic [27:0] b, output int bad);
    bad = 0;
    for (int s = 4; s < 32; s++)
    begin
      b[s-4] = w[63-2*s] ^ w[62-2*s];
      if (w[64-2*s] === w[63-2*s])
        bad++;
    end
  endtask

  task t_reset;
    rd_chk(spdte_pkg::CTRL_OFS, ALL, 32'h0);
    rd_chk(spdte_pkg::DIV_OFS, ALL, 32'h0);
    rd_chk(spdte_pkg::ROLE_OFS, ALL, 32'h0);
    rd_chk(spdte_pkg::STAT_OFS, ALL, 32'h0);
    wr(8'hC0, ALL);
    rd_chk(8'hC0, ALL, 32'h0);
    check(pin_oe, 2'h0);
  endtask

  task t_setup;
    for (int i = 0; i < 24; i++)
    begin
      mem[i] = 32'h13579BDF ^ (32'h01020409 * i);
      wr(spdte_pkg::MEM_BASE + 8'(4 * i), mem[i]);
    end
    for (int i = 0; i < 24; i++)
      rd_chk(spdte_pkg::MEM_BASE + 8'(4 * i), ALL, mem[i]);
    aud[0] = 24'h5A3C96;
    aud[1] = 24'hC30F81;
    wr(spdte_pkg::DATA0_OFS, {8'hFF, aud[0]});
    // pin 1 gets a left-aligned word that the host has shifted right by eight
    wr(spdte_pkg::DATA1_OFS, {aud[1], 8'h00} >> 8);
    wr(spdte_pkg::ROLE_OFS, 32'h3);
    wr(spdte_pkg::CTRL_OFS, 32'h6);
    check(pin_oe, 2'h0);
    // enable with loopback requested: loopback must drop, validity even set
    wr(spdte_pkg::CTRL_OFS, 32'h7);
    rd_chk(spdte_pkg::CTRL_OFS, 32'h2, 32'h0);
  endtask

  task t_block;
    logic [27:0] b, b1;
    int bad, bad1, k, n, l;
    for (int sub = 0; sub < 384; sub++)
    begin
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (s0 !== 1'b1 && n < 200);
      check(s1, 1'b1);
      decode(w0, b, bad);
      decode(w1, b1, bad1);
      k = sub / 2;
      l = (sub % 2 == 0) ? 0 : 6;
      check(bad + bad1, 0);
      check({^b, ^b1}, 2'h0);
      check(w0[63] ? w0[63:56] : ~w0[63:56], sub == 0 ? spdte_pkg::PRE_B :
        (l != 0 ? spdte_pkg::PRE_W : spdte_pkg::PRE_M));
      check(b[26], mem[l + k / 32][k % 32]);
      check(b[25], mem[12 + l + k / 32][k % 32]);
      check(b[24], l == 0);
      check(b[23:0], aud[0]);
      check(b1[23:0], aud[1]);
      check(b1[26:24], b[26:24]);
      if (sub == 383)
        rd_chk(spdte_pkg::STAT_OFS, 32'h000301FF, 32'h00010000);
    end
    wr(spdte_pkg::STAT_OFS, 32'h00010000);
    rd_chk(spdte_pkg::STAT_OFS, 32'h00010000, 32'h0);
  endtask

  task t_rate(input int unit);
    int run, bad, hits;
    logic last;
    run = -100000;
    bad = 0;
    hits = 0;
    last = pin_o[0];
    for (int i = 0; i < 800; i++)
    begin
      @(posedge clk);
      run++;
      if (pin_o[0] !== last)
      begin
        if (run > 0 && run % unit != 0)
          bad++;
        if (run == unit)
          hits++;
        run = 0;
        last = pin_o[0];
      end
    end
    check(bad, 0);
    check(hits > 0, 1'b1);
  endtask

  task t_clocking;
    wr(spdte_pkg::CTRL_OFS, 32'h0);
    wr(spdte_pkg::DIV_OFS, 32'h3);
    wr(spdte_pkg::CTRL_OFS, 32'h1);
    t_rate(4);
    wr(spdte_pkg::ROLE_OFS, 32'h1);
    repeat (3) @(posedge clk);
    check({pin_oe, pin_o[1]}, 3'h2);
    wr(spdte_pkg::CTRL_OFS, 32'h0);
    wr(spdte_pkg::DIV_OFS, 32'h0);
    ref_run <= 1'b1;
    wr(spdte_pkg::CTRL_OFS, 32'h11);
    t_rate(6);
    rd_chk(spdte_pkg::STAT_OFS, 32'h00020000, 32'h0);
    // reference stalls: the check must flag it within its limit
    ref_run <= 1'b0;
    repeat (300) @(posedge clk);
    rd_chk(spdte_pkg::STAT_OFS, 32'h00020000, 32'h00020000);
    // clear while the stall persists: the set must win
    wr(spdte_pkg::STAT_OFS, 32'h00020000);
    rd_chk(spdte_pkg::STAT_OFS, 32'h00020000, 32'h00020000);
    wr(spdte_pkg::CTRL_OFS, 32'h0);
    wr(spdte_pkg::STAT_OFS, 32'h00020000);
    rd_chk(spdte_pkg::STAT_OFS, 32'h00020000, 32'h0);
    repeat (3) @(posedge clk);
    check({pin_oe, pin_o}, 4'h0);
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    rst_b = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    ref_pin = 1'b0;
    ref_run = 1'b0;
    ref_cnt = 3'h0;
    fail_count = 0;
    num_checks = 0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_setup;
    t_block;
    t_clocking;
    give_verdict;
  end

  // whole run needs about 30000 cycles
  initial
  begin
    repeat (80000) @(posedge clk);
    fail_count++;
    give_verdict;
  end
endmodule
